// [hdl/vcrc_defs.svh]
// Purpose: constants for the channel 0 resource control and status registers
// Assumes: configuration accesses carry a dword address and four byte enables
// Notes: every offset and reset value lives here, with the map and status field positions
//
// Functional notes
// - control register at 164h, resets 800000FFh
// - bit 31 channel on, reads 1, unwritable
// - bits 26:24 channel number fixed 000b
// - reserved control fields always read zero
// - bits 19:17 arbitration choice read-only 000b
// - bit 16 table reload read-only 0b
// - bits 7:0 map classes onto channel 0
// - map bit 0 fixed 1, 7:1 writable
// - map resets to FFh
// - status register at 16Ah, read-only, resets 0000h
// - status bit 1 shows negotiation pending
// - status bit 0 table changed, refresh clears
`ifndef VCRC_DEFS_SVH
`define VCRC_DEFS_SVH

// register byte offsets in extended configuration space
`define VCRC_CTRL_OFS 12'h164
`define VCRC_STAT_OFS 12'h16a

// reset values
`define VCRC_CTRL_RST 32'h800000ff
`define VCRC_STAT_RST 16'h0000
`define VCRC_MAP_RST 8'hff

// fixed field values of the control register
`define VCRC_ON_VAL 1'h1
`define VCRC_CHNUM_VAL 3'h0
`define VCRC_ARB_VAL 3'h0
`define VCRC_RELOAD_VAL 1'h0

// field positions
`define VCRC_MAP_W 8
`define VCRC_MAP_LANE 0
`define VCRC_PEND_BIT 1
`define VCRC_TBL_BIT 0

`endif

// [hdl/vcrc_pkg.sv]
// Purpose: types shared by the channel 0 register bank
// Assumes: constants come from vcrc_defs.svh
// Notes: request and answer of the configuration port travel as structs
package vcrc_pkg;

    // one configuration access, presented for a single cycle
    typedef struct packed {
        logic rd;            // read strobe
        logic wr;            // write strobe
        logic [9:0] dwAddr;  // dword address, byte offset bits 11:2
        logic [3:0] byteEn;  // byte lanes of the write
        logic [31:0] wdata;  // write data
    } vcrc_req_s;

    // answer to a read, one cycle after the strobe
    typedef struct packed {
        logic valid;         // answer present
        logic hit;           // address belongs to this bank
        logic [31:0] data;   // read data
    } vcrc_rsp_s;

    // status flags of the channel
    typedef struct packed {
        logic negotiationPending; // channel negotiation in progress
        logic tableChanged;       // arbitration table differs from hardware
    } vcrc_stat_s;

endpackage

// [hdl/vcrc_regs.sv]
// Purpose: channel 0 resource control and status registers
// Assumes: configuration accesses arrive on the core clock, one cycle each
// Notes: read answers are registered; unmapped dwords answer zero, hit low
`timescale 1ns/1ps
`include "vcrc_defs.svh"

module vcrc_regs (
    // clock, reset and freeze
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // configuration access from the upstream link
    input wire vcrc_pkg::vcrc_req_s cfgReq,
    output vcrc_pkg::vcrc_rsp_s cfgRsp,
    // channel state reported by the link layer
    input wire logic negotiationBusy,
    input wire logic tableModified,
    input wire logic tableRefreshDone,
    // traffic class routing for the datapath
    output logic [7:0] trafficClassMap
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // offsets as vectors so the dword part can be sliced
    localparam logic [11:0] CtrlOfs = `VCRC_CTRL_OFS;
    localparam logic [11:0] StatOfs = `VCRC_STAT_OFS;

    // status is a half word; its lane inside the dword
    localparam logic StatUpper = StatOfs[1];

    logic ctrlHit; // access targets the control dword
    logic statHit; // access targets the status dword

    // combinational decode of the dword address
    always_comb begin
        ctrlHit = (cfgReq.dwAddr == CtrlOfs[11:2]);
        statHit = (cfgReq.dwAddr == StatOfs[11:2]);
    end

    ////////////////////////////////////////////////////////////////////////
    // traffic class map

    logic [7:0] mapQ; // stored map, bit 0 pinned to one
    logic [7:0] mapD; // next map
    logic mapWrite;   // write reaches the map byte lane

    // only lane 0 of the control dword holds writable bits;
    // the upper three lanes are hardwired and swallow writes
    always_comb begin
        mapWrite = cfgReq.wr && ctrlHit && cfgReq.byteEn[`VCRC_MAP_LANE];
    end

    // class 0 can never leave channel 0
    always_comb begin
        mapD[0] = 1'h1;
    end

    // classes 1 to 7 follow the last write
    genvar gi;
    generate
        for (gi = 1; gi < `VCRC_MAP_W; gi++) begin : g_map
            always_comb begin
                if (mapWrite) begin
                    mapD[gi] = cfgReq.wdata[gi];
                end else begin
                    mapD[gi] = mapQ[gi];
                end
            end
        end
    endgenerate

    // map register; reset wins over the freeze so a stalled core still
    // comes out of reset with every class on channel 0
    always_ff @(posedge clk) begin
        if (reset) begin
            mapQ <= `VCRC_MAP_RST;
        end else if (ce) begin
            mapQ <= mapD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags

    vcrc_pkg::vcrc_stat_s statQ; // live status
    vcrc_pkg::vcrc_stat_s statD; // next status

    // reset image of the status half word; only its two live bits are stored
    localparam logic [15:0] StatRst = `VCRC_STAT_RST;

    // pending follows the link layer, one cycle late;
    // the table flag is sticky and a new change beats a finishing refresh,
    // so an edit racing the refresh is never lost
    always_comb begin
        statD = statQ;
        statD.negotiationPending = negotiationBusy;
        if (tableModified) begin
            statD.tableChanged = 1'h1;
        end else if (tableRefreshDone) begin
            statD.tableChanged = 1'h0;
        end
    end

    // status register, written by hardware only
    always_ff @(posedge clk) begin
        if (reset) begin
            statQ <= StatRst[1:0];
        end else if (ce) begin
            statQ <= statD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [31:0] ctrlWord; // control register as software sees it
    logic [15:0] statWord; // status half word as software sees it
    vcrc_pkg::vcrc_rsp_s rspQ; // registered answer
    vcrc_pkg::vcrc_rsp_s rspD; // next answer

    // the control word is rebuilt from fixed fields and the stored map,
    // so there is no stored copy of the read-only bits to corrupt
    always_comb begin
        ctrlWord = {
            `VCRC_ON_VAL,
            4'h0,
            `VCRC_CHNUM_VAL,
            4'h0,
            `VCRC_ARB_VAL,
            `VCRC_RELOAD_VAL,
            8'h00,
            mapQ
        };
    end

    // status bits 15:2 are reserved and read zero
    always_comb begin
        statWord = {14'h0000, statQ};
    end

    // pick the answer; the lower half of the status dword is not ours
    always_comb begin
        rspD.valid = cfgReq.rd;
        rspD.hit = cfgReq.rd && (ctrlHit || statHit);
        rspD.data = 32'h00000000;
        if (cfgReq.rd && ctrlHit) begin
            rspD.data = ctrlWord;
        end else if (cfgReq.rd && statHit) begin
            if (StatUpper) begin
                rspD.data = {statWord, 16'h0000};
            end else begin
                rspD.data = {16'h0000, statWord};
            end
        end
    end

    // answer register; valid drops while frozen is not wanted, so the
    // whole answer simply holds
    always_ff @(posedge clk) begin
        if (reset) begin
            rspQ <= '0;
        end else if (ce) begin
            rspQ <= rspD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, straight from flip-flops

    always_comb begin
        cfgRsp = rspQ;
        trafficClassMap = mapQ;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (reset);

    // a taken control read answers the next cycle with fixed fields
    property p_ctrl_fixed;
        ce && cfgReq.rd && ctrlHit |=> cfgRsp.valid && cfgRsp.hit && cfgRsp.data[31:8] == 24'h800000;
    endproperty
    a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("control fixed bits wrong");

    // channel on bit stays one even after a write of zero
    property p_on_bit;
        ce && cfgReq.wr && ctrlHit && cfgReq.wdata[31] == 1'h0 ##1 ce && cfgReq.rd && ctrlHit
            |=> cfgRsp.data[31];
    endproperty
    a_on_bit: assert property (p_on_bit) else $error("channel on bit cleared");

    // channel number reads zero after any write
    property p_chnum;
        ce && cfgReq.wr && ctrlHit ##1 ce && cfgReq.rd && ctrlHit |=> cfgRsp.data[26:24] == 3'h0;
    endproperty
    a_chnum: assert property (p_chnum) else $error("channel number not zero");

    // reserved, arbitration choice and reload read zero after an all-ones write
    property p_fixed_zero;
        ce && cfgReq.wr && ctrlHit && cfgReq.wdata == 32'hffffffff ##1 ce && cfgReq.rd && ctrlHit
            |=> cfgRsp.data[30:8] == 23'h000000;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("read-only control bits moved");

    // a lane 0 write lands in map bits 7:1 with bit 0 still one
    property p_map_write;
        ce && cfgReq.wr && ctrlHit && cfgReq.byteEn[0]
            |=> trafficClassMap == {$past(cfgReq.wdata[7:1]), 1'h1};
    endproperty
    a_map_write: assert property (p_map_write) else $error("map write lost");

    // map comes out of reset as all ones
    property p_map_reset;
        $past(reset) |-> trafficClassMap == 8'hff;
    endproperty
    a_map_reset: assert property (p_map_reset) else $error("map reset value wrong");

    // status read shows pending and table flag in the upper half
    property p_stat_read;
        ce && cfgReq.rd && statHit
            |=> cfgRsp.hit && cfgRsp.data == {14'h0000, $past(statQ), 16'h0000};
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    // pending tracks the link layer one cycle later
    property p_pending;
        ce && negotiationBusy |=> statQ.negotiationPending;
    endproperty
    a_pending: assert property (p_pending) else $error("pending not shown");

    // table change sets the flag; a refresh alone clears it
    property p_table;
        (ce && tableModified |=> statQ.tableChanged)
        and (ce && tableRefreshDone && !tableModified |=> !statQ.tableChanged);
    endproperty
    a_table: assert property (p_table) else $error("table flag wrong");

    // writes without lane 0 leave the map untouched
    property p_ro_write;
        ce && cfgReq.wr && !cfgReq.byteEn[0] |=> $stable(trafficClassMap);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

    // class 0 is on channel 0 in every cycle, whatever was written
    property p_map_lsb;
        trafficClassMap[0] == 1'h1;
    endproperty
    a_map_lsb: assert property (p_map_lsb) else $error("class 0 left channel 0");

    // without a lane 0 control write the map keeps the last written value
    property p_map_hold;
        !(ce && cfgReq.wr && ctrlHit && cfgReq.byteEn[0]) |=> $stable(trafficClassMap);
    endproperty
    a_map_hold: assert property (p_map_hold) else $error("map moved without a write");

    // a control read returns the map as it stood when the read was taken
    property p_ctrl_map_read;
        ce && cfgReq.rd && ctrlHit |=> cfgRsp.data[7:0] == $past(trafficClassMap);
    endproperty
    a_ctrl_map_read: assert property (p_ctrl_map_read) else $error("map read back wrong");

    // pending drops one cycle after the link layer finishes
    property p_pending_low;
        ce && !negotiationBusy |=> !statQ.negotiationPending;
    endproperty
    a_pending_low: assert property (p_pending_low) else $error("pending stuck high");

    // reserved status bits and the foreign lower half read zero
    property p_stat_reserved;
        ce && cfgReq.rd && statHit |=> cfgRsp.data[31:18] == 14'h0000 && cfgRsp.data[15:0] == 16'h0000;
    endproperty
    a_stat_reserved: assert property (p_stat_reserved) else $error("status reserved bits set");

    // only the two register dwords claim a read
    property p_unmapped;
        ce && cfgReq.rd && !ctrlHit && !statHit |=> cfgRsp.valid && !cfgRsp.hit && cfgRsp.data == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

    // main scenarios
    property p_cov_map;
        ce && cfgReq.wr && ctrlHit && cfgReq.byteEn[0] && cfgReq.wdata[7:1] == 7'h00;
    endproperty
    c_cov_map: cover property (p_cov_map);

    property p_cov_race;
        ce && tableModified && tableRefreshDone;
    endproperty
    c_cov_race: cover property (p_cov_race);

    property p_cov_stat;
        ce && cfgReq.rd && statHit && statQ.negotiationPending;
    endproperty
    c_cov_stat: cover property (p_cov_stat);

    property p_cov_freeze;
        !ce && (cfgReq.rd || cfgReq.wr);
    endproperty
    c_cov_freeze: cover property (p_cov_freeze);

endmodule

// [test/vc0_resource_control_status_bench.sv]
// Purpose: self-checking bench for the channel 0 control and status registers
// Assumes: strobes are driven at the falling edge, answers come one cycle later
// Notes: a queue of expected {hit, data} answers is drained by a watching process
`timescale 1ns/1ps
`include "vcrc_defs.svh"

module vc0_resource_control_status_bench;
    // dword addresses of the two registers
    localparam logic [11:0] CTRL_OFS = `VCRC_CTRL_OFS;
    localparam logic [11:0] STAT_OFS = `VCRC_STAT_OFS;
    localparam logic [9:0] CTRL_DW = CTRL_OFS[11:2];
    localparam logic [9:0] STAT_DW = STAT_OFS[11:2];
    logic clk;
    logic reset;
    logic ce;
    logic negotiationBusy;
    logic tableModified;
    logic tableRefreshDone;
    vcrc_pkg::vcrc_req_s cfgReq;
    vcrc_pkg::vcrc_rsp_s cfgRsp;
    logic [7:0] trafficClassMap;
    logic [32:0] expQ[$]; // pending answers, {hit, data}
    logic [7:0] mapM; // model of the class map
    int failures;
    int checks;

    vcrc_regs u_dut (
        .clk(clk), .reset(reset), .ce(ce), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
        .negotiationBusy(negotiationBusy), .tableModified(tableModified),
        .tableRefreshDone(tableRefreshDone), .trafficClassMap(trafficClassMap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, verdict and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic finish_test();
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // generous: the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        failures++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // drivers and checks
    task automatic acc(input logic r, input logic w, input logic [9:0] a, input logic [3:0] be,
                       input logic [31:0] wd, input logic [32:0] e);
        cfgReq = '{rd: r, wr: w, dwAddr: a, byteEn: be, wdata: wd};
        // only a read taken with ce high earns an answer
        if (r && ce) begin
            expQ.push_back(e);
        end
        @(negedge clk);
    endtask

    task automatic idle();
        cfgReq.rd = 1'b0;
        cfgReq.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        checks++;
        if (got !== e) begin
            failures++;
            $display("BAD %0t map %h expected %h", $time, got, e);
        end
    endtask

    // control read expectation built from the fixed fields and the map
    function automatic logic [32:0] ctrlV(input logic [7:0] m);
        return {1'b1, 24'h800000, m};
    endfunction

    task automatic rdStat(input logic p, input logic t);
        acc(1'b1, 1'b0, STAT_DW, 4'h0, 32'h0, {1'b1, 14'h0, p, t, 16'h0});
        idle();
    endtask

    // write the control dword, read it back at once, then check the map port
    task automatic wrMap(input logic [31:0] wd, input logic [3:0] be);
        acc(1'b0, 1'b1, CTRL_DW, be, wd, 33'h0);
        if (be[0]) begin
            mapM = {wd[7:1], 1'b1};
        end
        acc(1'b1, 1'b0, CTRL_DW, 4'h0, 32'h0, ctrlV(mapM));
        idle();
        chk(trafficClassMap, mapM);
    endtask

    // answers are settled by the falling edge, so compare there
    always @(negedge clk) begin
        if (!reset && cfgRsp.valid === 1'b1) begin
            checks++;
            if (expQ.size() == 0) begin
                failures++;
                $display("BAD %0t answer without a read", $time);
            end else if ({cfgRsp.hit, cfgRsp.data} !== expQ[0]) begin
                failures++;
                $display("BAD %0t read %h expected %h", $time, {cfgRsp.hit, cfgRsp.data}, expQ[0]);
            end
            if (expQ.size() != 0) begin
                void'(expQ.pop_front());
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        negotiationBusy = 1'b0;
        tableModified = 1'b0;
        tableRefreshDone = 1'b0;
        cfgReq = '0;
        mapM = 8'hff;
        failures = 0;
        checks = 0;
        void'($urandom(80));
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk(trafficClassMap, 8'hff);
        // reset values back to back, then an unmapped dword
        acc(1'b1, 1'b0, CTRL_DW, 4'h0, 32'h0, 33'h1800000ff);
        acc(1'b1, 1'b0, STAT_DW, 4'h0, 32'h0, 33'h100000000);
        acc(1'b1, 1'b0, 10'h3ff, 4'h0, 32'h0, 33'h0);
        idle();
        wrMap(32'hffffffff, 4'hf);
        wrMap(32'h00000000, 4'hf);
        for (int i = 0; i < 12; i++) begin
            wrMap($urandom, 4'($urandom));
        end
        // status register ignores writes
        acc(1'b0, 1'b1, STAT_DW, 4'hf, 32'hffffffff, 33'h0);
        idle();
        rdStat(1'b0, 1'b0);
        // read and write in one cycle: the read returns the old map
        acc(1'b1, 1'b1, CTRL_DW, 4'h1, 32'h0, ctrlV(mapM));
        mapM = 8'h01;
        idle();
        chk(trafficClassMap, mapM);
        // strobes with ce low are ignored
        ce = 1'b0;
        acc(1'b1, 1'b1, CTRL_DW, 4'hf, 32'hfe, 33'h0);
        idle();
        ce = 1'b1;
        wrMap(32'h0, 4'h0);
        // hardware-set status flags
        negotiationBusy = 1'b1;
        @(negedge clk);
        rdStat(1'b1, 1'b0);
        negotiationBusy = 1'b0;
        tableModified = 1'b1;
        @(negedge clk);
        tableModified = 1'b0;
        rdStat(1'b0, 1'b1);
        tableModified = 1'b1;
        tableRefreshDone = 1'b1;
        @(negedge clk);
        tableModified = 1'b0;
        rdStat(1'b0, 1'b1);
        @(negedge clk);
        tableRefreshDone = 1'b0;
        rdStat(1'b0, 1'b0);
        // reset in mid-run restores the defaults
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        mapM = 8'hff;
        wrMap(32'h0, 4'h0);
        repeat (3) @(negedge clk);
        if (expQ.size() != 0) begin
            failures++;
            $display("BAD %0t reads left unanswered", $time);
        end
        finish_test();
    end
endmodule
